// ===== rtl/rms_reset_mode_select_latch.sv
// reset mode select latch: samples mode pins during reset, holds after
`timescale 1ns/1ps
`default_nettype none
`include "rms_regs.svh"
module rms_reset_mode_select_latch #(
  parameter int DATA_W = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic clock_mode_pin,
  input wire logic breakpoint_pin,
  output var rms_pkg::rms_boot_width_type boot_chip_select_width,
  output logic cs012_are_chip_selects,
  output logic cs345_are_chip_selects,
  output logic [`RMS_ADDR_LINES-1:0] high_addr_enable,
  output logic port_e_general_io,
  output logic port_f_general_io,
  output logic test_mode_enable,
  output var rms_pkg::rms_clk_src_type clock_source,
  output logic background_debug_enable
);
  import rms_pkg::*;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int ADDR_N = `RMS_ADDR_LINES;
  localparam int MODE_W = ADDR_N + 8;

  // ---------------------------------------------------------------
  // decoding helpers
  // ---------------------------------------------------------------
  // pulled low picks the alternate function
  function automatic logic sel_alt(input logic lvl);
    sel_alt = ~lvl;
  endfunction : sel_alt

  // ---------------------------------------------------------------
  // address range decode
  // ---------------------------------------------------------------
  logic [ADDR_N-1:0] addr_dec;

  // line 19+k is address when any of data(3+k)..data7 is low
  genvar g;
  generate
    for (g = 0; g < ADDR_N; g++) begin : g_addr
      assign addr_dec[g] = ~&data_in[`RMS_BIT_ADDR_HI:`RMS_BIT_ADDR_LO + g];
    end
  endgenerate

  // ---------------------------------------------------------------
  // mode latch: captured on every rising clock edge while rstn is low, held afterwards
  // ---------------------------------------------------------------
  rms_boot_width_type boot_q;
  rms_boot_width_type boot_d;
  logic cs012_q;
  logic cs012_d;
  logic cs345_q;
  logic cs345_d;
  logic [ADDR_N-1:0] addr_q;
  logic [ADDR_N-1:0] addr_d;
  logic port_e_q;
  logic port_e_d;
  logic port_f_q;
  logic port_f_d;
  logic test_q;
  logic test_d;
  rms_clk_src_type clk_src_q;
  rms_clk_src_type clk_src_d;
  logic debug_q;
  logic debug_d;
  logic [MODE_W-1:0] mode_all;

  always_comb begin
    boot_d = boot_q;
    cs012_d = cs012_q;
    cs345_d = cs345_q;
    addr_d = addr_q;
    port_e_d = port_e_q;
    port_f_d = port_f_q;
    test_d = test_q;
    clk_src_d = clk_src_q;
    debug_d = debug_q;
    if (!rstn) begin
      boot_d = data_in[`RMS_BIT_BOOT_WIDTH] ? RMS_BOOT_16BIT : RMS_BOOT_8BIT;
      cs012_d = data_in[`RMS_BIT_CS012];
      cs345_d = data_in[`RMS_BIT_CS345];
      addr_d = addr_dec;
      port_e_d = sel_alt(data_in[`RMS_BIT_PORT_E]);
      port_f_d = sel_alt(data_in[`RMS_BIT_PORT_F]);
      test_d = sel_alt(data_in[`RMS_BIT_TEST]);
      clk_src_d = clock_mode_pin ? RMS_CLK_LOOP : RMS_CLK_EXTERNAL;
      debug_d = sel_alt(breakpoint_pin);
    end
  end

  always_ff @(posedge clk) begin
    boot_q <= boot_d;
    cs012_q <= cs012_d;
    cs345_q <= cs345_d;
    addr_q <= addr_d;
    port_e_q <= port_e_d;
    port_f_q <= port_f_d;
    test_q <= test_d;
    clk_src_q <= clk_src_d;
    debug_q <= debug_d;
  end

  // ---------------------------------------------------------------
  // outputs straight from the latch
  // ---------------------------------------------------------------
  assign boot_chip_select_width = boot_q;
  assign cs012_are_chip_selects = cs012_q;
  assign cs345_are_chip_selects = cs345_q;
  assign high_addr_enable = addr_q;
  assign port_e_general_io = port_e_q;
  assign port_f_general_io = port_f_q;
  assign test_mode_enable = test_q;
  assign clock_source = clk_src_q;
  assign background_debug_enable = debug_q;
  assign mode_all = {boot_q, cs012_q, cs345_q, addr_q, port_e_q, port_f_q, test_q,
    clk_src_q, debug_q};

  // ---------------------------------------------------------------
  // checks: capture and hold
  // ---------------------------------------------------------------
  property p_hold;
    @(posedge clk) disable iff (!rstn)
      $past(rstn) |-> $stable(mode_all);
  endproperty
  a_hold: assert property (p_hold) else $error("mode latch changed after reset");

  property p_sample;
    @(posedge clk) !rstn |=> (clock_source == RMS_CLK_LOOP) == $past(clock_mode_pin)
      && background_debug_enable == !$past(breakpoint_pin);
  endproperty
  a_sample: assert property (p_sample) else $error("pins not sampled in reset");

  property p_boot;
    @(posedge clk) $rose(rstn) |->
      (boot_chip_select_width == RMS_BOOT_16BIT) == $past(data_in[`RMS_BIT_BOOT_WIDTH]);
  endproperty
  a_boot: assert property (p_boot) else $error("boot width wrong");

  property p_test;
    @(posedge clk) $rose(rstn) |->
      test_mode_enable == !$past(data_in[`RMS_BIT_TEST]);
  endproperty
  a_test: assert property (p_test) else $error("test mode wrong");

  property p_clk;
    @(posedge clk) $rose(rstn) |->
      (clock_source == RMS_CLK_LOOP) == $past(clock_mode_pin);
  endproperty
  a_clk: assert property (p_clk) else $error("clock source wrong");

  property p_bdm;
    @(posedge clk) $rose(rstn) |->
      background_debug_enable == !$past(breakpoint_pin);
  endproperty
  a_bdm: assert property (p_bdm) else $error("debug mode wrong");

  property p_cs012;
    @(posedge clk) $rose(rstn) |->
      cs012_are_chip_selects == $past(data_in[`RMS_BIT_CS012]);
  endproperty
  a_cs012: assert property (p_cs012) else $error("chip select 0-2 mode wrong");

  property p_cs345;
    @(posedge clk) $rose(rstn) |->
      cs345_are_chip_selects == $past(data_in[`RMS_BIT_CS345]);
  endproperty
  a_cs345: assert property (p_cs345) else $error("chip select 3-5 mode wrong");

  property p_port_e;
    @(posedge clk) $rose(rstn) |->
      port_e_general_io == !$past(data_in[`RMS_BIT_PORT_E]);
  endproperty
  a_port_e: assert property (p_port_e) else $error("port e mode wrong");

  property p_port_f;
    @(posedge clk) $rose(rstn) |->
      port_f_general_io == !$past(data_in[`RMS_BIT_PORT_F]);
  endproperty
  a_port_f: assert property (p_port_f) else $error("port f mode wrong");

  // ---------------------------------------------------------------
  // checks: address range
  // ---------------------------------------------------------------
  property p_addr_any;
    @(posedge clk) $rose(rstn) |->
      high_addr_enable[0] == ($past(data_in[`RMS_BIT_ADDR_HI:`RMS_BIT_ADDR_LO]) != '1);
  endproperty
  a_addr_any: assert property (p_addr_any) else $error("lowest address line wrong");

  property p_addr_top;
    @(posedge clk) $rose(rstn) |->
      high_addr_enable[ADDR_N-1] == !$past(data_in[`RMS_BIT_ADDR_HI]);
  endproperty
  a_addr_top: assert property (p_addr_top) else $error("top address line wrong");

  property p_addr_one;
    @(posedge clk) $rose(rstn) && $past(data_in[`RMS_BIT_ADDR_HI:`RMS_BIT_ADDR_LO]) ==
      {{(ADDR_N-1){1'b1}}, 1'b0} |-> high_addr_enable == {{(ADDR_N-1){1'b0}}, 1'b1};
  endproperty
  a_addr_one: assert property (p_addr_one) else $error("single address line wrong");

  property p_addr_mono;
    @(posedge clk) disable iff (!rstn)
      (high_addr_enable[ADDR_N-1:1] & ~high_addr_enable[ADDR_N-2:0]) == '0;
  endproperty
  a_addr_mono: assert property (p_addr_mono) else $error("address range has a gap");

  // ---------------------------------------------------------------
  // covers
  // ---------------------------------------------------------------
  c_test: cover property (@(posedge clk) $rose(rstn) && test_mode_enable);
  c_ext: cover property (@(posedge clk) $rose(rstn) && clock_source == RMS_CLK_EXTERNAL);
  c_full_addr: cover property (@(posedge clk) rstn && high_addr_enable == 5'h1F);
  c_8bit: cover property (@(posedge clk) rstn && boot_chip_select_width == RMS_BOOT_8BIT);
  c_bdm: cover property (@(posedge clk) $rose(rstn) && background_debug_enable);
endmodule : rms_reset_mode_select_latch
`default_nettype wire

// ===== rtl/rms_regs.svh
// constants for the reset mode select latch
// How it works
// - data0 high 16-bit boot port, low 8-bit
// - data11 low enables test mode
// - clock pin high loop oscillator, low external
// - breakpoint pin low enables background debug
// - data1/data2 pick chip selects or alternates
// - data3..7 low convert chip selects to address
// - data8/data9 low give ports E and F
`ifndef RMS_REGS_SVH
`define RMS_REGS_SVH
`define RMS_BIT_BOOT_WIDTH 0
`define RMS_BIT_CS012 1
`define RMS_BIT_CS345 2
`define RMS_BIT_ADDR_LO 3
`define RMS_BIT_ADDR_HI 7
`define RMS_BIT_PORT_E 8
`define RMS_BIT_PORT_F 9
`define RMS_BIT_TEST 11
`define RMS_ADDR_LINES 5
`define RMS_DATA_RESET 16'hFFFF
`endif

// ===== rtl/rms_pkg.sv
// types for the reset mode select latch
package rms_pkg;
  typedef enum logic {RMS_CLK_EXTERNAL, RMS_CLK_LOOP} rms_clk_src_type;
  typedef enum logic {RMS_BOOT_8BIT, RMS_BOOT_16BIT} rms_boot_width_type;
endpackage : rms_pkg

// ===== tb/rms_board_model.sv
// board straps: drive mode pins in reset, wiggle them afterwards
`timescale 1ns/1ps
`default_nettype none
module rms_board_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [17:0] strap,
  output logic [15:0] data_in,
  output logic clock_mode_pin,
  output logic breakpoint_pin
);
  logic tog_q;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tog_q <= 1'b0;
    end else begin
      tog_q <= ~tog_q;
    end
  end
  // straps held in reset, toggling junk after
  assign {breakpoint_pin, clock_mode_pin, data_in} = rstn ? ({18{tog_q}} ^ ~strap) : strap;
endmodule : rms_board_model
`default_nettype wire

// ===== tb/rms_reset_mode_select_latch_tb.sv
// self-checking bench for the reset mode select latch
`timescale 1ns/1ps
`default_nettype none
module rms_reset_mode_select_latch_tb;
  import rms_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [17:0] strap = 18'h3FFFF;
  logic [17:0] p;
  logic [15:0] data_in;
  logic cmp, bkp, c012, c345, pe, pf, tm, bdm;
  logic [4:0] hae;
  rms_boot_width_type bw;
  rms_clk_src_type cs;
  int n_fail = 0;
  int samples_checked = 0;
  int seed = 12;
  int hist[$];
  rms_board_model rms_board_model_inst (.clk(clk), .rstn(rstn), .strap(strap),
    .data_in(data_in), .clock_mode_pin(cmp), .breakpoint_pin(bkp));
  rms_reset_mode_select_latch rms_reset_mode_select_latch_inst (.clk(clk), .rstn(rstn),
    .data_in(data_in), .clock_mode_pin(cmp), .breakpoint_pin(bkp),
    .boot_chip_select_width(bw), .cs012_are_chip_selects(c012),
    .cs345_are_chip_selects(c345), .high_addr_enable(hae), .port_e_general_io(pe),
    .port_f_general_io(pf), .test_mode_enable(tm), .clock_source(cs),
    .background_debug_enable(bdm));
  task automatic conclude;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude
  task automatic check(input string nm, input logic [4:0] seen, input logic [4:0] expd);
    samples_checked++;
    if (seen !== expd) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, expd, seen);
    end
  endtask : check
  task automatic check_all(input int v);
    logic [17:0] s;
    logic [4:0] a;
    s = v[17:0];
    a = 5'h00;
    for (int k = 0; k < 5; k++) begin
      for (int j = k; j < 5; j++) if (!s[3+j]) a[k] = 1'b1;
    end
    check("boot", 5'(bw), 5'(s[0]));
    check("cs012", 5'(c012), 5'(s[1]));
    check("cs345", 5'(c345), 5'(s[2]));
    check("addr", hae, a);
    check("port_e_general_io", 5'(pe), 5'(!s[8]));
    check("port_f_general_io", 5'(pf), 5'(!s[9]));
    check("test", 5'(tm), 5'(!s[11]));
    check("clksrc", 5'(cs), 5'(s[16]));
    check("debug", 5'(bdm), 5'(!s[17]));
  endtask : check_all
  initial forever #20 clk = ~clk;
  initial begin
    #40000;
    n_fail++;
    conclude;
  end
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    hist.push_back(int'(strap));
    @(posedge clk);
    #1 check_all(hist[$]);
    for (int i = 0; i < 40; i++) begin
      p = (i < 19) ? ~(18'h1 << i) : 18'($random(seed));
      @(posedge clk);
      rstn <= 1'b0;
      strap <= 18'($random(seed));
      @(posedge clk);
      strap <= p;
      @(posedge clk);
      rstn <= 1'b1;
      hist.push_back(int'(p));
      repeat (3) @(posedge clk);
      #1 check_all(hist[$]);
    end
    conclude;
  end
endmodule : rms_reset_mode_select_latch_tb
`default_nettype wire
